// *** osc_ctl_defines.svh ***
// Register offsets, field positions, reset values and counts of the clock source control.
`ifndef OSC_CTL_DEFINES_SVH
`define OSC_CTL_DEFINES_SVH

`define OFF_SYSTEM_CONTROL_0      12'h000
`define OFF_CTRL1      12'h004
`define OFF_CONFIG     12'h008
`define OFF_WAKE_EN    12'h00C
`define OFF_STATUS     12'h010
`define OFF_IRQ_STAT   12'h014
`define OFF_IRQ_MASK   12'h018
`define OFF_COMMAND    12'h01C

`define SYSTEM_CONTROL_0_PWR_MODE 0
`define SYSTEM_CONTROL_0_LCD_SRC  1
`define SYSTEM_CONTROL_0_LCD_KEEP 2
`define SYSTEM_CONTROL_0_TMR_SRC  5
`define CTRL1_XT_KEEP  0
`define CTRL1_SYS_KEEP 1
`define CTRL1_RC_ON    2
`define CFG_SRC_LO     0
`define CFG_FRQ_LO     2
`define CFG_XT_OPT     4
`define CFG_RC_OPT     5
`define CFG_WDT_RC     6
`define CMD_PWR_DOWN   0

`define SYSTEM_CONTROL_0_RST      8'h00
`define CTRL1_RST      8'h05
`define CONFIG_RST     8'h62
`define WAKE_EN_RST    8'h00

`define SRC_XTAL       2'h0
`define SRC_ERC        2'h1
`define SRC_FRC        2'h2
`define FRQ_ILLEGAL    2'h3

`define IRQ_WAKE       0
`define IRQ_XT_VALID   1
`define IRQ_SWITCHED   2

`define XT_START_QUICK 13'h0400
`define XT_START_LOW   13'h1000
`define SYNC_BITS      16
`endif

// *** osc_ctl_pkg.sv ***
// Types shared by the clock source control files.
package osc_ctl_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic sys;
    logic slow_rc;
    logic slow_xtal;
  } osc_en_t;
  typedef struct packed {
    logic watchdog_clk;
    logic lcd_sub_clk;
    logic timer_low_freq_clk;
  } lf_clk_t;
  typedef enum logic {SW_RUN, SW_PICK} sw_state_t;
endpackage

// *** level_sync.sv ***
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/1ns
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_r[i] <= 1'b0;
        hold_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= async_in[i];
        hold_r[i] <= meta_r[i];
      end
    end
  end

  assign sync_out = hold_r;
endmodule

// *** osc_source_ctl.sv ***
// Clock source selection, power-down gating and wake-up control with an APB register port.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "osc_ctl_defines.svh"

// Notes on behaviour
// - System clock comes from crystal, external RC or internal fast RC by option.
// - Slow RC or slow crystal may feed watchdog, LCD and timer slow clocks.
// - In power-down the system and slow crystal oscillators run or stop by their own control bits; slow RC runs while watchdog, timer or kept LCD uses it.
// - Interrupt, enabled port A transition, watchdog or timer overflow ends power-down.
// - Internal fast RC runs at one of three selectable fixed frequencies.
// - With internal fast RC selected both oscillator pins become ordinary I/O.
// - With external RC selected only the first oscillator pin is used.
// - Slow crystal is an option and counts valid only after start-up delay.
// - Power-mode bit zero means quick start, one means low power.
// - Power-on clears the power-mode bit, starting the crystal in quick start.
// - Slow crystal keeps running in either mode; low power only slows start-up.
// - Power-down stops the system clock; timer clocks come from independent sources.
// - Slow RC is an option and keeps running in power-down when the watchdog, the timer or an LCD with its keep bit set uses it.
// - Slow RC may stop only when nothing selects it, or in power-down when the LCD alone selects it and its keep bit is clear.
module osc_source_ctl (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire osc_ctl_pkg::apb_req_t apb_req,
  output osc_ctl_pkg::apb_rsp_t     apb_rsp,
  input  wire logic                 ext_crystal_osc,
  input  wire logic                 ext_rc_osc,
  input  wire logic                 int_fast_rc_osc,
  input  wire logic                 low_speed_crystal_osc,
  input  wire logic                 int_slow_rc_osc,
  input  wire logic [7:0]           port_a_in,
  input  wire logic                 irq_req,
  input  wire logic                 watchdog_overflow,
  input  wire logic                 timer_overflow,
  output logic                      sys_clk_out,
  output logic                      sys_clk_run,
  output osc_ctl_pkg::osc_en_t      osc_en,
  output osc_ctl_pkg::lf_clk_t      lf_clk,
  output logic [1:0]                fast_rc_freq_sel,
  output logic                      crystal_power_mode_bit,
  output logic [1:0]                osc_pins_gpio,
  output logic                      irq
);
  import osc_ctl_pkg::*;

  logic [15:0] sync_w;
  logic [2:0]  sys_lvl;
  logic        xt_lvl;
  logic        rc_lvl;
  logic [7:0]  port_s;
  logic        irq_s;
  logic        wdt_s;
  logic        tmr_s;

  level_sync #(.W(`SYNC_BITS)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({timer_overflow, watchdog_overflow, irq_req, port_a_in, int_slow_rc_osc,
                low_speed_crystal_osc, int_fast_rc_osc, ext_rc_osc, ext_crystal_osc}),
    .sync_out (sync_w)
  );

  assign sys_lvl = sync_w[2:0];
  assign xt_lvl  = sync_w[3];
  assign rc_lvl  = sync_w[4];
  assign port_s  = sync_w[12:5];
  assign irq_s   = sync_w[13];
  assign wdt_s   = sync_w[14];
  assign tmr_s   = sync_w[15];

  // Register file and APB slave.
  logic [7:0]  system_control_0_r, system_control_0_nxt;
  logic [7:0]  ctrl1_r, ctrl1_nxt;
  logic [7:0]  cfg_r, cfg_nxt;
  logic [7:0]  wake_en_r, wake_en_nxt;
  logic [2:0]  irq_stat_r, irq_stat_nxt;
  logic [2:0]  irq_mask_r, irq_mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        wr_acc;
  logic        setup;
  logic        mapped;
  logic        pd_cmd;
  logic [2:0]  irq_evt;
  logic [7:0]  status_w;

  assign setup  = apb_req.psel && !apb_req.penable;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign mapped = (apb_req.paddr[11:5] == 7'h00) && (apb_req.paddr[1:0] == 2'h0);
  assign pd_cmd = wr_acc && (apb_req.paddr == `OFF_COMMAND) && apb_req.pwdata[`CMD_PWR_DOWN];

  always_comb begin
    system_control_0_nxt    = system_control_0_r;
    ctrl1_nxt    = ctrl1_r;
    cfg_nxt      = cfg_r;
    wake_en_nxt  = wake_en_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    prdata_nxt   = prdata_r;
    if (wr_acc) begin
      unique case (apb_req.paddr)
        `OFF_SYSTEM_CONTROL_0:    system_control_0_nxt = apb_req.pwdata[7:0];
        `OFF_CTRL1:    ctrl1_nxt = apb_req.pwdata[7:0];
        `OFF_CONFIG:   cfg_nxt = apb_req.pwdata[7:0];
        `OFF_WAKE_EN:  wake_en_nxt = apb_req.pwdata[7:0];
        `OFF_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~apb_req.pwdata[2:0];
        `OFF_IRQ_MASK: irq_mask_nxt = apb_req.pwdata[2:0];
        default: ;
      endcase
    end
    irq_stat_nxt = irq_stat_nxt | irq_evt;
    if (setup) begin
      unique case (apb_req.paddr)
        `OFF_SYSTEM_CONTROL_0:    prdata_nxt = {24'h000000, system_control_0_r};
        `OFF_CTRL1:    prdata_nxt = {24'h000000, ctrl1_r};
        `OFF_CONFIG:   prdata_nxt = {24'h000000, cfg_r};
        `OFF_WAKE_EN:  prdata_nxt = {24'h000000, wake_en_r};
        `OFF_STATUS:   prdata_nxt = {24'h000000, status_w};
        `OFF_IRQ_STAT: prdata_nxt = {29'h0000000, irq_stat_r};
        `OFF_IRQ_MASK: prdata_nxt = {29'h0000000, irq_mask_r};
        default:       prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      system_control_0_r    <= `SYSTEM_CONTROL_0_RST;
      ctrl1_r    <= `CTRL1_RST;
      cfg_r      <= `CONFIG_RST;
      wake_en_r  <= `WAKE_EN_RST;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      prdata_r   <= 32'h00000000;
    end else begin
      system_control_0_r    <= system_control_0_nxt;
      ctrl1_r    <= ctrl1_nxt;
      cfg_r      <= cfg_nxt;
      wake_en_r  <= wake_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      prdata_r   <= prdata_nxt;
    end
  end

  assign apb_rsp.prdata  = prdata_r;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  assign irq             = |(irq_stat_r & irq_mask_r);

  // Power-down entry and wake-up.
  logic       pd_r, pd_nxt;
  logic [7:0] port_d_r;
  logic       wake;

  assign wake = irq_s || wdt_s || tmr_s || |((port_s ^ port_d_r) & wake_en_r);

  always_comb begin
    pd_nxt = pd_r;
    if (pd_r && wake) begin
      pd_nxt = 1'b0;
    end else if (!pd_r && pd_cmd) begin
      pd_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_r     <= 1'b0;
      port_d_r <= 8'h00;
    end else begin
      pd_r     <= pd_nxt;
      port_d_r <= port_s;
    end
  end

  // Oscillator enables.
  logic    [1:0] tgt_src;
  logic          rc_in_use;
  osc_en_t       en_r, en_nxt;

  assign tgt_src = (cfg_r[`CFG_SRC_LO+:2] == `SRC_XTAL) ? `SRC_XTAL :
                   (cfg_r[`CFG_SRC_LO+:2] == `SRC_ERC) ? `SRC_ERC : `SRC_FRC;
  assign rc_in_use = cfg_r[`CFG_WDT_RC] || !system_control_0_r[`SYSTEM_CONTROL_0_TMR_SRC] ||
                     (!system_control_0_r[`SYSTEM_CONTROL_0_LCD_SRC] && (!pd_r || system_control_0_r[`SYSTEM_CONTROL_0_LCD_KEEP]));

  always_comb begin
    en_nxt.sys       = !pd_r || ctrl1_r[`CTRL1_SYS_KEEP];
    en_nxt.slow_xtal = cfg_r[`CFG_XT_OPT] && (!pd_r || ctrl1_r[`CTRL1_XT_KEEP]);
    en_nxt.slow_rc   = cfg_r[`CFG_RC_OPT] &&
                       (rc_in_use || (!pd_r && ctrl1_r[`CTRL1_RC_ON]));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r <= '0;
    end else begin
      en_r <= en_nxt;
    end
  end

  assign osc_en = en_r;

  // Slow crystal start-up; the power mode changes the wait, never the enable.
  logic [12:0] xt_cnt_r, xt_cnt_nxt;
  logic        xt_valid_r, xt_valid_nxt;
  logic        xt_d_r;
  logic [12:0] xt_limit;

  assign xt_limit = system_control_0_r[`SYSTEM_CONTROL_0_PWR_MODE] ? `XT_START_LOW : `XT_START_QUICK;

  always_comb begin
    xt_cnt_nxt   = xt_cnt_r;
    xt_valid_nxt = xt_valid_r;
    if (!en_r.slow_xtal) begin
      xt_cnt_nxt   = 13'h0000;
      xt_valid_nxt = 1'b0;
    end else if (!xt_valid_r && xt_lvl && !xt_d_r) begin
      xt_cnt_nxt = xt_cnt_r + 13'h0001;
      if (xt_cnt_nxt >= xt_limit) begin
        xt_valid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xt_cnt_r   <= 13'h0000;
      xt_valid_r <= 1'b0;
      xt_d_r     <= 1'b0;
    end else begin
      xt_cnt_r   <= xt_cnt_nxt;
      xt_valid_r <= xt_valid_nxt;
      xt_d_r     <= xt_lvl;
    end
  end

  // Glitch-free system clock switch.
  sw_state_t  sw_r, sw_nxt;
  logic [1:0] cur_r, cur_nxt;
  logic       gate_r, gate_nxt;
  logic       cur_lvl;
  logic       sys_clk_r;
  logic       switched;

  assign cur_lvl = sys_lvl[cur_r];

  always_comb begin
    sw_nxt   = sw_r;
    cur_nxt  = cur_r;
    gate_nxt = gate_r;
    switched = 1'b0;
    unique case (sw_r)
      SW_RUN: begin
        if (tgt_src != cur_r && !cur_lvl) begin
          gate_nxt = 1'b0;
          cur_nxt  = tgt_src;
          sw_nxt   = SW_PICK;
        end
      end
      SW_PICK: begin
        if (tgt_src != cur_r) begin
          cur_nxt = tgt_src;
        end else if (!cur_lvl) begin
          gate_nxt = 1'b1;
          sw_nxt   = SW_RUN;
          switched = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_r      <= SW_PICK;
      cur_r     <= `SRC_FRC;
      gate_r    <= 1'b0;
      sys_clk_r <= 1'b0;
    end else begin
      sw_r      <= sw_nxt;
      cur_r     <= cur_nxt;
      gate_r    <= gate_nxt;
      sys_clk_r <= gate_r && !pd_r && cur_lvl;
    end
  end

  assign sys_clk_out = sys_clk_r;
  assign sys_clk_run = !pd_r;

  // Low-frequency clocks, each from slow RC or a started slow crystal.
  lf_clk_t lf_r, lf_nxt;
  logic    xt_ok;
  logic    rc_ok;

  assign xt_ok = xt_lvl && xt_valid_r;
  assign rc_ok = rc_lvl && en_r.slow_rc;

  always_comb begin
    lf_nxt.watchdog_clk       = cfg_r[`CFG_WDT_RC] ? rc_ok : xt_ok;
    lf_nxt.lcd_sub_clk        = system_control_0_r[`SYSTEM_CONTROL_0_LCD_SRC] ? xt_ok : rc_ok;
    lf_nxt.timer_low_freq_clk = system_control_0_r[`SYSTEM_CONTROL_0_TMR_SRC] ? xt_ok : rc_ok;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lf_r <= '0;
    end else begin
      lf_r <= lf_nxt;
    end
  end

  assign lf_clk = lf_r;

  assign fast_rc_freq_sel = (cfg_r[`CFG_FRQ_LO+:2] == `FRQ_ILLEGAL) ? 2'h0 :
                            cfg_r[`CFG_FRQ_LO+:2];
  assign crystal_power_mode_bit = system_control_0_r[`SYSTEM_CONTROL_0_PWR_MODE];
  assign osc_pins_gpio[0] = (tgt_src == `SRC_FRC);
  assign osc_pins_gpio[1] = (tgt_src != `SRC_XTAL);

  assign irq_evt  = {switched, xt_valid_nxt && !xt_valid_r, pd_r && wake};
  assign status_w = {pd_r, xt_valid_r, gate_r, sw_r == SW_RUN, cur_r, en_r.slow_rc,
                     en_r.slow_xtal};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pwr_mode_reset_a: assert property ($fell(rst) |-> !crystal_power_mode_bit)
    else $error("power mode bit not cleared at reset");
  sysclk_stop_a: assert property (pd_r ##1 pd_r |-> !sys_clk_out)
    else $error("system clock runs in power-down");
  wake_exit_a: assert property (pd_r && wake |=> !pd_r && irq_stat_r[`IRQ_WAKE])
    else $error("wake event did not end power-down");
  frc_pins_a: assert property (tgt_src == `SRC_FRC |-> osc_pins_gpio == 2'h3)
    else $error("pins not released for fast RC");
  erc_pins_a: assert property (tgt_src == `SRC_ERC |-> osc_pins_gpio == 2'h2)
    else $error("wrong pin use for external RC");
  rc_kept_a: assert property (cfg_r[`CFG_RC_OPT] && rc_in_use |=> osc_en.slow_rc)
    else $error("slow RC stopped while in use");
  xt_keep_pd_a: assert property (pd_r && !ctrl1_r[`CTRL1_XT_KEEP] |=> !osc_en.slow_xtal)
    else $error("slow crystal runs against its control bit");
  xt_valid_a: assert property ($rose(xt_valid_r) |->
    $past(xt_cnt_r) + 13'h0001 >= $past(xt_limit))
    else $error("slow crystal valid before start-up count");
  // The output register already holds the low level that the gate decision was taken on.
  glitch_free_a: assert property ($changed(gate_r) |-> !$past(cur_lvl) && !sys_clk_r)
    else $error("clock gate changed during high phase");
  fast_rc_sel_a: assert property (fast_rc_freq_sel != `FRQ_ILLEGAL)
    else $error("illegal fast RC frequency code");

  switch_done_c: cover property (sw_r == SW_PICK ##[1:20] sw_r == SW_RUN);
  pd_wake_c: cover property (pd_r ##[1:50] !pd_r);
  xt_valid_c: cover property ($rose(xt_valid_r));
  irq_out_c: cover property ($rose(irq));
endmodule

// *** osc_model.sv ***
// Behavioural oscillators that feed the clock source inputs.
`timescale 1ns/1ns
module osc_model #(
  parameter int HALF_XT = 175,
  parameter int HALF_RC = 225,
  parameter int HALF_FR = 125,
  parameter int HALF_LX = 150,
  parameter int HALF_LR = 400
) (
  input  osc_ctl_pkg::osc_en_t en,
  output logic                 ext_crystal_osc,
  output logic                 ext_rc_osc,
  output logic                 int_fast_rc_osc,
  output logic                 low_speed_crystal_osc,
  output logic                 int_slow_rc_osc
);
  import osc_ctl_pkg::*;
  // Periods are far shorter than real parts so start-up counts end in a short run.
  initial begin
    {ext_crystal_osc, ext_rc_osc, int_fast_rc_osc} = 3'b000;
    {low_speed_crystal_osc, int_slow_rc_osc} = 2'b00;
  end
  // A disabled oscillator rests low, as a stopped crystal or RC network does.
  always #HALF_XT ext_crystal_osc = en.sys & ~ext_crystal_osc;
  always #HALF_RC ext_rc_osc = en.sys & ~ext_rc_osc;
  always #HALF_FR int_fast_rc_osc = en.sys & ~int_fast_rc_osc;
  always #HALF_LX low_speed_crystal_osc = en.slow_xtal & ~low_speed_crystal_osc;
  always #HALF_LR int_slow_rc_osc = en.slow_rc & ~int_slow_rc_osc;
endmodule

// *** tb.sv ***
// Self-checking testbench for the clock source control.
`timescale 1ns/1ns
`include "osc_ctl_defines.svh"
module tb;
  import osc_ctl_pkg::*;
  logic        clk, rst, irq_req, watchdog_overflow, timer_overflow;
  apb_req_t    apb_req;
  apb_rsp_t    apb_rsp;
  logic        ext_crystal_osc, ext_rc_osc, int_fast_rc_osc, low_speed_crystal_osc;
  logic        int_slow_rc_osc, sys_clk_out, sys_clk_run, crystal_power_mode_bit, irq;
  logic [7:0]  port_a_in;
  logic [1:0]  fast_rc_freq_sel, osc_pins_gpio;
  osc_en_t     osc_en;
  lf_clk_t     lf_clk;
  logic [31:0] rdv;
  logic        erv, pt, pw, pl;
  int          err_count, cmp_count, cyc, n_t, n_w, n_l;
  localparam logic [1:0] PINS [3] = '{2'b00, 2'b10, 2'b11};

  osc_source_ctl DUT (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ext_crystal_osc(ext_crystal_osc), .ext_rc_osc(ext_rc_osc),
    .int_fast_rc_osc(int_fast_rc_osc), .low_speed_crystal_osc(low_speed_crystal_osc),
    .int_slow_rc_osc(int_slow_rc_osc), .port_a_in(port_a_in), .irq_req(irq_req),
    .watchdog_overflow(watchdog_overflow), .timer_overflow(timer_overflow),
    .sys_clk_out(sys_clk_out), .sys_clk_run(sys_clk_run), .osc_en(osc_en), .lf_clk(lf_clk),
    .fast_rc_freq_sel(fast_rc_freq_sel), .crystal_power_mode_bit(crystal_power_mode_bit),
    .osc_pins_gpio(osc_pins_gpio), .irq(irq));
  osc_model osc (.en(osc_en), .ext_crystal_osc(ext_crystal_osc), .ext_rc_osc(ext_rc_osc),
    .int_fast_rc_osc(int_fast_rc_osc), .low_speed_crystal_osc(low_speed_crystal_osc),
    .int_slow_rc_osc(int_slow_rc_osc));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end

  task results;
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // The request stays put until pready is seen high at a rising edge.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rdv = apb_rsp.prdata;
    erv = apb_rsp.pslverr;
    apb_req <= '0;
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv & m, e);
  endtask
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    rst = 1'b1;
    apb_req = '0;
    port_a_in = 8'h00;
    {irq_req, watchdog_overflow, timer_overflow} = 3'b000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(1);
    chk(32'(crystal_power_mode_bit), 32'h0);
    rdc(`OFF_SYSTEM_CONTROL_0, 32'hFF, 32'h00);
    rdc(`OFF_CTRL1, 32'hFF, `CTRL1_RST);
    rdc(`OFF_CONFIG, 32'hFF, `CONFIG_RST);
    chk(32'(osc_pins_gpio), 32'h3);
    chk(32'(osc_en.slow_rc), 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(erv), 32'h1);
    chk(rdv, 32'h0);
    apb(1'b1, `OFF_STATUS, 32'hFF);
    chk(32'(erv), 32'h0);
    for (int f = 0; f < 4; f++) begin
      wr(`OFF_CONFIG, 32'h62 | 32'(f << 2));
      chk(32'(fast_rc_freq_sel), (f == 3) ? 32'h0 : 32'(f));
    end
    wr(`OFF_CONFIG, 32'h63);
    chk(32'(osc_pins_gpio), 32'h3);
    // The switch done at reset left its flag set; clear it so each switch is seen anew.
    wr(`OFF_IRQ_STAT, 32'h4);
    wr(`OFF_IRQ_MASK, 32'h4);
    chk(32'(irq), 32'h0);
    for (int s = 0; s < 3; s++) begin
      wr(`OFF_CONFIG, 32'h60 | 32'(s));
      chk(32'(osc_pins_gpio), 32'(PINS[s]));
      for (int i = 0; i < 400 && irq !== 1'b1; i++) wait_cyc(1);
      chk(32'(irq), 32'h1);
      rdc(`OFF_STATUS, 32'hC, 32'(s) << 2);
      wr(`OFF_IRQ_STAT, 32'h4);
      chk(32'(irq), 32'h0);
    end
    // Move every slow clock user to the crystal, then start its quick count.
    wr(`OFF_SYSTEM_CONTROL_0, 32'h22);
    wr(`OFF_CTRL1, 32'h01);
    wr(`OFF_CONFIG, 32'h32);
    wait_cyc(1);
    chk(32'(osc_en.slow_rc), 32'h0);
    chk(32'(osc_en.slow_xtal), 32'h1);
    wait_cyc(5500);
    rdc(`OFF_STATUS, 32'h40, 32'h00);
    wait_cyc(1200);
    rdc(`OFF_STATUS, 32'h40, 32'h40);
    rdc(`OFF_IRQ_STAT, 32'h2, 32'h2);
    wr(`OFF_SYSTEM_CONTROL_0, 32'h03);
    chk(32'(crystal_power_mode_bit), 32'h1);
    wait_cyc(1);
    chk(32'(osc_en.slow_rc), 32'h1);
    wait_cyc(100);
    rdc(`OFF_STATUS, 32'h40, 32'h40);
    wr(`OFF_CONFIG, 32'h22);
    wait_cyc(10);
    wr(`OFF_CONFIG, 32'h32);
    wait_cyc(6700);
    rdc(`OFF_STATUS, 32'h40, 32'h00);
    wait_cyc(18800);
    rdc(`OFF_STATUS, 32'h40, 32'h40);
    wr(`OFF_WAKE_EN, 32'h01);
    wr(`OFF_IRQ_MASK, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(`OFF_CTRL1, 32'(k != 3) | 32'((k & 1) << 1));
      wr(`OFF_COMMAND, 32'h1);
      wait_cyc(4);
      chk(32'(sys_clk_run), 32'h0);
      chk(32'(sys_clk_out), 32'h0);
      chk(32'(osc_en.sys), 32'(k & 1));
      chk(32'(osc_en.slow_xtal), 32'(k != 3));
      if (k == 0) begin
        {n_t, n_w, n_l, pt, pw, pl} = '0;
        repeat (200) begin
          wait_cyc(1);
          n_t += int'(lf_clk.timer_low_freq_clk !== pt);
          n_w += int'(lf_clk.watchdog_clk !== pw);
          n_l += int'(lf_clk.lcd_sub_clk !== pl);
          {pt, pw, pl} = {lf_clk.timer_low_freq_clk, lf_clk.watchdog_clk, lf_clk.lcd_sub_clk};
        end
        chk(32'(n_t > 4), 32'h1);
        chk(32'(n_w > 4), 32'h1);
        chk(32'(n_l > 4), 32'h1);
      end
      @(posedge clk);
      if (k == 3) begin
        port_a_in <= 8'h02;
        wait_cyc(8);
        chk(32'(sys_clk_run), 32'h0);
        @(posedge clk);
      end
      case (k)
        0: irq_req <= 1'b1;
        1: watchdog_overflow <= 1'b1;
        2: timer_overflow <= 1'b1;
        default: port_a_in <= 8'h03;
      endcase
      for (int i = 0; i < 12 && sys_clk_run !== 1'b1; i++) wait_cyc(1);
      chk(32'(sys_clk_run), 32'h1);
      @(posedge clk);
      {irq_req, watchdog_overflow, timer_overflow} <= 3'b000;
      port_a_in <= 8'h00;
      wait_cyc(4);
      rdc(`OFF_IRQ_STAT, 32'h1, 32'h1);
      chk(32'(irq), 32'(k > 0));
      wr(`OFF_IRQ_MASK, 32'h1);
      chk(32'(irq), 32'h1);
      wr(`OFF_IRQ_STAT, 32'h1);
      chk(32'(irq), 32'h0);
    end
    results();
  end
endmodule
